// ---- bpagu_top.sv ----
// x write address unit with bit-reversed mode, plus program space
// address forming, with its control registers on an avalon-mm slave.
// assumes pipeline inputs are synchronous to clk and held for one cycle.
//
// Notes on behaviour
// - bit-reverse needs pointer select not 15, enable set, pre/post increment
// - bit-reverse enable is bit 15 of bit-reverse control
// - only word writes with pre/post increment are bit-reversed
// - pivot lives in bits 14..0 of bit-reverse control
// - bit-reversed addresses are word aligned; pivot scaled to bytes
// - bit-reverse adds pivot to pointer, mode offset ignored
// - bit-reverse beats modulo in write unit; read unit keeps modulo
// - 16-entry buffer visits indices in mirrored four-bit order
// - bridges 24-bit program words and 16-bit data words
// - table address is table page above 16-bit ea
// - table page bit 7 picks configuration over user memory
// - window address is visibility page above low 15 ea bits
// - window address bit 23 held zero, user memory only
// - window is read-only and yields the low word only
// - ea bit 15 left out of the window address; address bit 15 from page bit 0
// - table access reaches any byte or word, upper byte included
// - only the x write unit does bit-reverse, on writes
// - pivot and pointers both kept in normal bit order; only the adder mirrors them
// - window active when ea bit 15 set and window enable set
`timescale 1ns/1ps
`default_nettype none
`include "bpagu_map.svh"

module bpagu_top (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // avalon-mm register slave
  input  wire logic [4:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // x write address request
  input  wire logic                   xw_req,
  input  wire logic [3:0]             xw_wreg,
  input  wire logic [15:0]            xw_ptr,
  input  wire bpagu_pkg::bpagu_mode_e xw_mode,
  input  wire logic                   xw_byte,
  input  wire logic [15:0]            xw_offset,
  // x write address answer
  output logic                        xw_valid,
  output logic      [15:0]            xw_ea,
  output logic      [15:0]            xw_ptr_new,
  output logic                        xw_ptr_we,
  output logic                        xw_bitrev,
  output logic                        xw_modulo,
  // x read address unit modulo steering
  input  wire logic                   xr_req,
  input  wire logic [3:0]             xr_wreg,
  output logic                        xr_valid,
  output logic                        xr_modulo,
  // program space access request
  input  wire logic                   pa_req,
  input  wire bpagu_pkg::bpagu_kind_e pa_kind,
  input  wire logic [15:0]            pa_ea,
  input  wire logic [22:0]            pa_pc,
  input  wire logic                   pa_write,
  input  wire logic                   pa_high,
  // program space access answer
  output logic                        pa_valid,
  output logic      [23:0]            pa_addr,
  output logic                        pa_cfg,
  output logic                        pa_lsw_only,
  output logic                        pa_refused,
  output logic                        pa_bytesel,
  output logic                        pa_upper
);
  import bpagu_pkg::*;

  // ****************************************
  // helpers
  // ****************************************

  // merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] lane16(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : lane16

  // pointer select field 15 means the feature is off
  function automatic logic sel_hit(
    input logic [3:0] sel,
    input logic [3:0] wreg
  );
    return (sel != `BPAGU_NO_PTR) && (sel == wreg);
  endfunction : sel_hit

  // ****************************************
  // state
  // ****************************************

  bpagu_state_s s_q;
  bpagu_state_s s_d;

  logic [3:0]  psel;
  logic [3:0]  xwm;
  logic        br_en;
  logic        xmod_en;
  logic        is_inc;
  logic        is_dec;
  logic        is_pre;
  logic        is_modify;
  logic        br_act;
  logic [15:0] br_sum;
  logic [15:0] norm_ptr;
  logic        bus_req;
  logic        bus_take;
  logic [31:0] rd_mux;

  logic [23:0] pf_addr;
  logic        pf_valid;
  logic        pf_cfg;
  logic        pf_lsw;
  logic        pf_ref;

  // ****************************************
  // submodules
  // ****************************************

  bpagu_bitrev u_bitrev (
    .ptr      (xw_ptr),
    .modifier (s_q.brc[`BPAGU_BRC_MOD_MSB:0]),
    .sum      (br_sum)
  );

  bpagu_progaddr u_progaddr (
    .kind            (pa_kind),
    .ea              (pa_ea),
    .pc              (pa_pc),
    .is_write        (pa_write),
    .table_page      (s_q.tpg),
    .visibility_page (s_q.vpg),
    .win_en          (s_q.core[`BPAGU_CORE_WIN_BIT]),
    .paddr           (pf_addr),
    .prog_valid      (pf_valid),
    .cfg_space       (pf_cfg),
    .lsw_only        (pf_lsw),
    .refused         (pf_ref)
  );

  // ****************************************
  // write address unit decode
  // ****************************************

  assign psel    = s_q.crc[`BPAGU_CRC_PSEL_LSB +: 4];
  assign xwm     = s_q.crc[`BPAGU_CRC_XWM_LSB +: 4];
  assign br_en   = s_q.brc[`BPAGU_BRC_EN_BIT];
  assign xmod_en = s_q.crc[`BPAGU_CRC_XMOD_BIT];

  assign is_inc    = (xw_mode == am_pre_inc) || (xw_mode == am_post_inc);
  assign is_dec    = (xw_mode == am_pre_dec) || (xw_mode == am_post_dec);
  assign is_pre    = (xw_mode == am_pre_inc) || (xw_mode == am_pre_dec);
  assign is_modify = is_inc || is_dec;

  // byte writes and other modes fall back to the normal path
  assign br_act = br_en && sel_hit(psel, xw_wreg) && is_inc && !xw_byte;

  // normal modified pointer: offset carries its own sign
  assign norm_ptr = xw_ptr + xw_offset;

  // ****************************************
  // bus decode
  // ****************************************

  // one wait cycle per access; the answer lands on the second edge
  assign bus_req  = avs_read || avs_write;
  assign bus_take = bus_req && s_q.ack;

  always_comb begin
    rd_mux = 32'h00000000;
    case (avs_address)
      `BPAGU_OFS_BRC: begin
        rd_mux[15:0] = s_q.brc;
      end
      `BPAGU_OFS_TPG: begin
        rd_mux[7:0] = s_q.tpg;
      end
      `BPAGU_OFS_VPG: begin
        rd_mux[7:0] = s_q.vpg;
      end
      `BPAGU_OFS_CRC: begin
        rd_mux[15:0] = s_q.crc;
      end
      `BPAGU_OFS_CORE: begin
        rd_mux[15:0] = s_q.core;
      end
      `BPAGU_OFS_STAT: begin
        rd_mux[15:0]                = s_q.xw_ea;
        rd_mux[`BPAGU_STAT_BR_BIT]  = s_q.xw_bitrev;
        rd_mux[`BPAGU_STAT_MOD_BIT] = s_q.xw_modulo;
        rd_mux[`BPAGU_STAT_REF_BIT] = s_q.pa_refused;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // ****************************************
  // next state
  // ****************************************

  always_comb begin
    s_d = s_q;

    // bus handshake and register writes
    s_d.ack = bus_req && !s_q.ack;
    if (bus_req && !s_q.ack) begin
      s_d.rdata = rd_mux;
    end
    if (bus_take && avs_write) begin
      case (avs_address)
        `BPAGU_OFS_BRC: begin
          s_d.brc = lane16(s_q.brc, avs_writedata, avs_byteenable);
        end
        `BPAGU_OFS_TPG: begin
          if (avs_byteenable[0]) begin
            s_d.tpg = avs_writedata[7:0];
          end
        end
        `BPAGU_OFS_VPG: begin
          if (avs_byteenable[0]) begin
            s_d.vpg = avs_writedata[7:0];
          end
        end
        `BPAGU_OFS_CRC: begin
          s_d.crc = lane16(s_q.crc, avs_writedata, avs_byteenable);
        end
        `BPAGU_OFS_CORE: begin
          s_d.core = lane16(s_q.core, avs_writedata, avs_byteenable);
        end
        default: begin
          s_d.ack = s_d.ack;
        end
      endcase
    end

    // write address unit; only this unit ever bit-reverses
    s_d.xw_valid = xw_req;
    if (xw_req) begin
      s_d.xw_bitrev = br_act;
      // modulo correction suppressed here while bit-reverse is active
      s_d.xw_modulo = xmod_en && sel_hit(xwm, xw_wreg) && !br_act;
      if (br_act) begin
        // pivot always added, mode offset ignored
        s_d.xw_ptr_new = br_sum;
        s_d.xw_ptr_we  = 1'b1;
        s_d.xw_ea      = is_pre ? br_sum : {xw_ptr[15:1], 1'b0};
      end else begin
        s_d.xw_ptr_new = is_modify ? norm_ptr : xw_ptr;
        s_d.xw_ptr_we  = is_modify;
        case (xw_mode)
          am_pre_inc, am_pre_dec: begin
            s_d.xw_ea = norm_ptr;
          end
          am_reg_offset, am_lit_offset: begin
            s_d.xw_ea = norm_ptr;
          end
          default: begin
            s_d.xw_ea = xw_ptr;
          end
        endcase
      end
    end else begin
      s_d.xw_ptr_we = 1'b0;
    end

    // read address unit keeps its modulo correction regardless
    s_d.xr_valid = xr_req;
    if (xr_req) begin
      s_d.xr_modulo = xmod_en && sel_hit(xwm, xr_wreg);
    end

    // program space address forming
    s_d.pa_valid = pa_req && pf_valid;
    if (pa_req) begin
      s_d.pa_addr     = pf_addr;
      s_d.pa_cfg      = pf_cfg;
      s_d.pa_lsw_only = pf_lsw;
      s_d.pa_refused  = pf_ref;
      // table path exposes byte select and the upper byte lane
      s_d.pa_bytesel  = (pa_kind == pk_table) && pa_ea[0];
      s_d.pa_upper    = (pa_kind == pk_table) && pa_high;
    end
  end

  // ****************************************
  // registers
  // ****************************************

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q            <= '0;
      s_q.brc        <= `BPAGU_RST_BRC;
      s_q.tpg        <= `BPAGU_RST_TPG;
      s_q.vpg        <= `BPAGU_RST_VPG;
      s_q.crc        <= `BPAGU_RST_CRC;
      s_q.core       <= `BPAGU_RST_CORE;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  assign avs_waitrequest = bus_req && !s_q.ack;
  assign avs_readdata    = s_q.rdata;

  assign xw_valid   = s_q.xw_valid;
  assign xw_ea      = s_q.xw_ea;
  assign xw_ptr_new = s_q.xw_ptr_new;
  assign xw_ptr_we  = s_q.xw_ptr_we;
  assign xw_bitrev  = s_q.xw_bitrev;
  assign xw_modulo  = s_q.xw_modulo;

  assign xr_valid  = s_q.xr_valid;
  assign xr_modulo = s_q.xr_modulo;

  assign pa_valid    = s_q.pa_valid;
  assign pa_addr     = s_q.pa_addr;
  assign pa_cfg      = s_q.pa_cfg;
  assign pa_lsw_only = s_q.pa_lsw_only;
  assign pa_refused  = s_q.pa_refused;
  assign pa_bytesel  = s_q.pa_bytesel;
  assign pa_upper    = s_q.pa_upper;

endmodule : bpagu_top
`default_nettype wire

// ---- bpagu_map.svh ----
// offsets, field positions and reset values of the address unit registers
// assumes byte addresses on a 32-bit avalon slave, one register per word
`ifndef BPAGU_MAP_SVH
`define BPAGU_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define BPAGU_OFS_BRC       5'h00
`define BPAGU_OFS_TPG       5'h04
`define BPAGU_OFS_VPG       5'h08
`define BPAGU_OFS_CRC       5'h0C
`define BPAGU_OFS_CORE      5'h10
`define BPAGU_OFS_STAT      5'h14

// ****************************************
// field positions
// ****************************************
`define BPAGU_BRC_EN_BIT    15
`define BPAGU_BRC_MOD_MSB   14
`define BPAGU_CRC_XMOD_BIT  15
`define BPAGU_CRC_XWM_LSB   0
`define BPAGU_CRC_PSEL_LSB  8
`define BPAGU_CORE_WIN_BIT  2
`define BPAGU_TPG_CFG_BIT   7
`define BPAGU_STAT_BR_BIT   16
`define BPAGU_STAT_MOD_BIT  17
`define BPAGU_STAT_REF_BIT  18
`define BPAGU_NO_PTR        4'hF

// ****************************************
// reset values
// ****************************************
`define BPAGU_RST_BRC       16'h0000
`define BPAGU_RST_TPG       8'h00
`define BPAGU_RST_VPG       8'h00
`define BPAGU_RST_CRC       16'hFFFF
`define BPAGU_RST_CORE      16'h0000

`endif

// ---- bpagu_pkg.sv ----
// types shared by the address unit modules
// assumes bpagu_map.svh is available on the include path
package bpagu_pkg;

  // effective address modes offered by the execution pipeline
  typedef enum logic [2:0] {
    am_direct,
    am_indirect,
    am_post_inc,
    am_post_dec,
    am_pre_inc,
    am_pre_dec,
    am_reg_offset,
    am_lit_offset
  } bpagu_mode_e;

  // kind of program space access
  typedef enum logic [1:0] {
    pk_fetch,
    pk_table,
    pk_data
  } bpagu_kind_e;

  typedef struct packed {
    logic [15:0] brc;
    logic [7:0]  tpg;
    logic [7:0]  vpg;
    logic [15:0] crc;
    logic [15:0] core;
    logic        ack;
    logic [31:0] rdata;
    logic        xw_valid;
    logic [15:0] xw_ea;
    logic [15:0] xw_ptr_new;
    logic        xw_ptr_we;
    logic        xw_bitrev;
    logic        xw_modulo;
    logic        xr_valid;
    logic        xr_modulo;
    logic        pa_valid;
    logic [23:0] pa_addr;
    logic        pa_cfg;
    logic        pa_lsw_only;
    logic        pa_refused;
    logic        pa_bytesel;
    logic        pa_upper;
  } bpagu_state_s;

endpackage : bpagu_pkg

// ---- bpagu_bitrev.sv ----
// reverse-carry adder for bit-reversed pointer updates
// assumes the caller decides when the result is used
`timescale 1ns/1ps
`default_nettype none

module bpagu_bitrev (
  // pointer and pivot
  input  wire logic [15:0] ptr,
  input  wire logic [14:0] modifier,
  // updated pointer
  output logic      [15:0] sum
);

  logic [15:0] scaled;
  logic [15:0] ptr_rev;
  logic [15:0] mod_rev;
  logic [15:0] sum_rev;

  // pivot counts words; shift to byte units
  assign scaled = {modifier, 1'b0};

  // adding mirrored operands sends the carry from msb toward lsb
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_rev
      assign ptr_rev[i] = ptr[15-i];
      assign mod_rev[i] = scaled[15-i];
      assign sum[15-i]  = (i == 15) ? 1'b0 : sum_rev[i];
    end
  endgenerate

  assign sum_rev = ptr_rev + mod_rev;

endmodule : bpagu_bitrev
`default_nettype wire

// ---- bpagu_progaddr.sv ----
// program space address former for fetch, table and window accesses
// assumes purely combinational use; the caller registers the results
`timescale 1ns/1ps
`default_nettype none
`include "bpagu_map.svh"

module bpagu_progaddr (
  // access description
  input  wire bpagu_pkg::bpagu_kind_e kind,
  input  wire logic [15:0]            ea,
  input  wire logic [22:0]            pc,
  input  wire logic                   is_write,
  // page registers and window enable
  input  wire logic [7:0]             table_page,
  input  wire logic [7:0]             visibility_page,
  input  wire logic                   win_en,
  // formed address
  output logic      [23:0]            paddr,
  output logic                        prog_valid,
  output logic                        cfg_space,
  output logic                        lsw_only,
  output logic                        refused
);
  import bpagu_pkg::*;

  logic win_hit;

  always_comb begin
    win_hit    = (kind == pk_data) && ea[15] && win_en;
    paddr      = 24'h000000;
    prog_valid = 1'b0;
    cfg_space  = 1'b0;
    lsw_only   = 1'b0;
    refused    = 1'b0;
    case (kind)
      pk_fetch: begin
        paddr      = {1'b0, pc[22:1], 1'b0};
        prog_valid = 1'b1;
      end
      pk_table: begin
        paddr      = {table_page, ea};
        cfg_space  = table_page[`BPAGU_TPG_CFG_BIT];
        prog_valid = 1'b1;
      end
      pk_data: begin
        // ea[15] dropped; page bit 0 lands on address bit 15
        paddr      = {1'b0, visibility_page, ea[14:0]};
        lsw_only   = win_hit;
        refused    = win_hit && is_write;
        prog_valid = win_hit && !is_write;
      end
      default: begin
        paddr = 24'h000000;
      end
    endcase
  end

endmodule : bpagu_progaddr
`default_nettype wire

// ---- bpagu_wfile_model.sv ----
// pointer register file standing in for the execution pipeline
// assumes ptr_we comes one cycle after the request that named wreg
`timescale 1ns/1ps
`default_nettype none

module bpagu_wfile_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // request side
  input  wire logic        req,
  input  wire logic [3:0]  wreg,
  // write-back from the address unit
  input  wire logic        ptr_we,
  input  wire logic [15:0] ptr_new,
  // pointer offered to the next request
  output logic      [15:0] ptr
);
  logic [15:0] w_q [16];
  logic [3:0]  sel_q;

  assign ptr = w_q[wreg];

  // write-back lands on the register named one cycle earlier
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_q <= 4'h0;
      for (int i = 0; i < 16; i++) w_q[i] <= 16'h0000;
    end else begin
      if (req) sel_q <= wreg;
      if (ptr_we) w_q[sel_q] <= ptr_new;
    end
  end
endmodule : bpagu_wfile_model
`default_nettype wire

// ---- bpagu_chk_sva.sv ----
// port-level checks for the address unit top
// assumes one clock domain; bound to every instance of the top
`timescale 1ns/1ps
`default_nettype none

module bpagu_chk (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // write address unit
  input  wire logic                   xw_req,
  input  wire bpagu_pkg::bpagu_mode_e xw_mode,
  input  wire logic                   xw_byte,
  input  wire logic                   xw_valid,
  input  wire logic [15:0]            xw_ea,
  input  wire logic [15:0]            xw_ptr_new,
  input  wire logic                   xw_ptr_we,
  input  wire logic                   xw_bitrev,
  input  wire logic                   xw_modulo,
  // program access
  input  wire logic                   pa_req,
  input  wire bpagu_pkg::bpagu_kind_e pa_kind,
  input  wire logic [15:0]            pa_ea,
  input  wire logic [22:0]            pa_pc,
  input  wire logic                   pa_write,
  input  wire logic                   pa_valid,
  input  wire logic [23:0]            pa_addr,
  input  wire logic                   pa_cfg,
  input  wire logic                   pa_lsw_only
);
  import bpagu_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ****
  // bit-reversed write unit
  // ****
  br_byte_a: assert property (xw_req && xw_byte |=> !xw_bitrev)
    else $error("byte write was bit-reversed");
  br_mode_a: assert property (xw_req && !(xw_mode inside {am_pre_inc, am_post_inc})
    |=> !xw_bitrev) else $error("bit-reverse outside increment modes");
  br_lsb_a: assert property (xw_valid && xw_bitrev |-> !xw_ea[0] && !xw_ptr_new[0])
    else $error("bit-reversed address is odd");
  br_wb_a: assert property (xw_req ##1 xw_bitrev |-> xw_valid && xw_ptr_we)
    else $error("bit-reversed pointer not written back");
  br_prio_a: assert property (xw_valid && xw_bitrev |-> !xw_modulo)
    else $error("modulo kept beside bit-reverse");

  // ****
  // program space address
  // ****
  fetch_addr_a: assert property (pa_req && pa_kind == pk_fetch |=> pa_valid &&
    pa_addr[22:1] == 22'($past(pa_pc) >> 1) && !pa_addr[23] && !pa_addr[0])
    else $error("fetch address malformed");
  table_addr_a: assert property (pa_req && pa_kind == pk_table |=> pa_valid &&
    pa_addr[15:0] == $past(pa_ea) && pa_cfg == pa_addr[23]) else $error("table address bad");
  win_user_a: assert property (pa_valid && pa_lsw_only |-> !pa_addr[23] && !pa_cfg)
    else $error("window reached configuration space");
  win_write_a: assert property (pa_req && pa_kind == pk_data && pa_write |=> !pa_valid)
    else $error("window write was issued");
  win_off_a: assert property (pa_req && pa_kind == pk_data && !pa_ea[15] |=> !pa_valid)
    else $error("window opened below the upper half");
  win_low_a: assert property (pa_req && pa_kind == pk_data |=>
    !pa_valid || pa_addr[14:0] == 15'($past(pa_ea))) else $error("window low bits wrong");

  cover property (xw_valid && xw_bitrev);
  cover property (pa_valid && pa_lsw_only);
  cover property (pa_valid && pa_cfg);
endmodule : bpagu_chk

bind bpagu_top bpagu_chk u_chk (.*);
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the address unit top
// assumes the pointer model stands in for the pipeline register file
`timescale 1ns/1ps
`default_nettype none
`include "bpagu_map.svh"

module tb_top;
  import bpagu_pkg::*;
  typedef struct {logic [3:0] r; bpagu_mode_e m; logic b; logic [15:0] p, o, ea, pn;
                  logic we, br, mo;} bpagu_row_s;
  logic        clk = 1'b0, nrst = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'h3, xw_wreg = 4'h0, xr_wreg = 4'h0;
  logic        xw_req = 1'b0, xw_byte = 1'b0, xr_req = 1'b0;
  logic        pa_req = 1'b0, pa_write = 1'b0, pa_high = 1'b0;
  logic [15:0] xw_ptr = 16'h0, xw_offset = 16'h0, pa_ea = 16'h0, xw_ea, xw_ptr_new, pm_ptr;
  bpagu_mode_e xw_mode = am_direct;
  bpagu_kind_e pa_kind = pk_fetch;
  logic [22:0] pa_pc = 23'h0;
  logic        xw_valid, xw_ptr_we, xw_bitrev, xw_modulo, xr_valid, xr_modulo;
  logic        pa_valid, pa_cfg, pa_lsw_only, pa_refused, pa_bytesel, pa_upper;
  logic [23:0] pa_addr;
  int          num_errors = 0, tests_run = 0;
  // pivot 8 words, pointer 3 selected for both bit-reverse and modulo
  bpagu_row_s  rows [9] = '{
    '{4'h3, am_post_inc, 1'b0, 16'h1000, 16'h0004, 16'h1000, 16'h1010, 1'b1, 1'b1, 1'b0},
    '{4'h3, am_pre_inc, 1'b0, 16'h1010, 16'h0002, 16'h1008, 16'h1008, 1'b1, 1'b1, 1'b0},
    '{4'h3, am_post_inc, 1'b1, 16'h1000, 16'h0001, 16'h1000, 16'h1001, 1'b1, 1'b0, 1'b1},
    '{4'h3, am_post_dec, 1'b0, 16'h1000, 16'hFFFE, 16'h1000, 16'h0FFE, 1'b1, 1'b0, 1'b1},
    '{4'h3, am_pre_dec, 1'b0, 16'h1000, 16'hFFFE, 16'h0FFE, 16'h0FFE, 1'b1, 1'b0, 1'b1},
    '{4'h4, am_post_inc, 1'b0, 16'h2000, 16'h0002, 16'h2000, 16'h2002, 1'b1, 1'b0, 1'b0},
    '{4'h3, am_post_inc, 1'b0, 16'h1001, 16'h0002, 16'h1000, 16'h1010, 1'b1, 1'b1, 1'b0},
    '{4'h3, am_lit_offset, 1'b0, 16'h1000, 16'h0006, 16'h1006, 16'h1000, 1'b0, 1'b0, 1'b1},
    '{4'h3, am_indirect, 1'b0, 16'h1000, 16'h0002, 16'h1000, 16'h1000, 1'b0, 1'b0, 1'b1}};

  always #4 clk = ~clk;

  bpagu_top dut (.*);
  bpagu_wfile_model pm (
    .clk     (clk),
    .nrst    (nrst),
    .req     (xw_req),
    .wreg    (xw_wreg),
    .ptr_we  (xw_ptr_we),
    .ptr_new (xw_ptr_new),
    .ptr     (pm_ptr)
  );

  // ****
  // helpers
  // ****
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 16) begin
        num_errors++;
        tally_and_finish();
      end
      @(posedge clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, {16'h0000, d}, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("register", {16'h0000, e}, q);
  endtask : rd

  task automatic xw_op(input bpagu_row_s t);
    xw_req <= 1'b1;
    xw_wreg <= t.r;
    xw_mode <= t.m;
    xw_byte <= t.b;
    xw_ptr <= t.p;
    xw_offset <= t.o;
    @(posedge clk);
    xw_req <= 1'b0;
    @(negedge clk);
    chk("write ea", {16'h0000, t.ea}, {16'h0000, xw_ea});
    chk("write pointer", {16'h0000, t.pn}, {16'h0000, xw_ptr_new});
    chk("write flags", {28'h0, 1'b1, t.we, t.br, t.mo},
        {28'h0, xw_valid, xw_ptr_we, xw_bitrev, xw_modulo});
    @(posedge clk);
  endtask : xw_op

  // e holds valid, refused and the expected address
  task automatic pa_op(input bpagu_kind_e k, input logic [15:0] ea, input logic w,
                       input logic h, input logic [25:0] e);
    pa_req <= 1'b1;
    pa_kind <= k;
    pa_ea <= ea;
    pa_write <= w;
    pa_high <= h;
    @(posedge clk);
    pa_req <= 1'b0;
    @(negedge clk);
    chk("program valid refused", {30'h0, e[25:24]}, {30'h0, pa_valid, pa_refused});
    if (e[25]) chk("program address", {8'h00, e[23:0]}, {8'h00, pa_addr});
    if (k == pk_table) chk("table flags", {29'h0, e[23], h, ea[0]},
                           {29'h0, pa_cfg, pa_upper, pa_bytesel});
    if (k == pk_data && e[25]) chk("window low word", 32'h1, {31'h0, pa_lsw_only});
    @(posedge clk);
  endtask : pa_op

  function automatic logic [15:0] rv(input int i);
    rv = {11'h000, i[0], i[1], i[2], i[3], 1'b0};
  endfunction : rv

  // ****
  // main sequence
  // ****
  initial begin
    bpagu_row_s t;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(`BPAGU_OFS_BRC, 16'h0000);
    rd(`BPAGU_OFS_CRC, 16'hFFFF);
    rd(`BPAGU_OFS_VPG, 16'h0000);
    rd(5'h18, 16'h0000);
    wr(`BPAGU_OFS_BRC, 16'h8008);
    wr(`BPAGU_OFS_CRC, 16'h8303);
    rd(`BPAGU_OFS_BRC, 16'h8008);
    // pointer 3 starts at zero, so the 32-byte buffer is aligned
    for (int i = 0; i < 16; i++) begin
      t = '{4'h3, am_post_inc, 1'b0, pm_ptr, 16'h0002, rv(i), rv(i + 1), 1'b1, 1'b1, 1'b0};
      xw_op(t);
      @(posedge clk);
    end
    foreach (rows[i]) xw_op(rows[i]);
    xr_req <= 1'b1;
    xr_wreg <= 4'h3;
    @(posedge clk);
    xr_req <= 1'b0;
    @(negedge clk);
    chk("read modulo", 32'h3, {30'h0, xr_valid, xr_modulo});
    @(posedge clk);
    wr(`BPAGU_OFS_BRC, 16'h0008);
    t = '{4'h3, am_post_inc, 1'b0, 16'h1000, 16'h0004, 16'h1000, 16'h1004, 1'b1, 1'b0, 1'b1};
    xw_op(t);
    // pointer select 15 keeps bit-reverse off while enabled; modulo disabled too
    wr(`BPAGU_OFS_BRC, 16'h8008);
    wr(`BPAGU_OFS_CRC, 16'h0F0F);
    t = '{4'hF, am_post_inc, 1'b0, 16'h1000, 16'h0002, 16'h1000, 16'h1002, 1'b1, 1'b0, 1'b0};
    xw_op(t);
    rd(`BPAGU_OFS_STAT, 16'h1000);
    wr(`BPAGU_OFS_TPG, 16'h0080);
    wr(`BPAGU_OFS_VPG, 16'h0081);
    wr(`BPAGU_OFS_CORE, 16'h0004);
    pa_pc <= 23'h2AB5CD;
    pa_op(pk_fetch, 16'h0000, 1'b0, 1'b0, {2'b10, 24'h2AB5CC});
    pa_op(pk_table, 16'h1235, 1'b1, 1'b1, {2'b10, 24'h801235});
    pa_op(pk_data, 16'h9234, 1'b0, 1'b0, {2'b10, 24'h409234});
    pa_op(pk_data, 16'h9234, 1'b1, 1'b0, {2'b01, 24'h000000});
    pa_op(pk_data, 16'h1234, 1'b0, 1'b0, {2'b00, 24'h000000});
    wr(`BPAGU_OFS_VPG, 16'h0080);
    pa_op(pk_data, 16'hFFFF, 1'b0, 1'b0, {2'b10, 24'h407FFF});
    wr(`BPAGU_OFS_TPG, 16'h007F);
    pa_op(pk_table, 16'hFFFF, 1'b0, 1'b0, {2'b10, 24'h7FFFFF});
    wr(`BPAGU_OFS_CORE, 16'h0000);
    pa_op(pk_data, 16'h9234, 1'b0, 1'b0, {2'b00, 24'h000000});
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(`BPAGU_OFS_CRC, 16'hFFFF);
    rd(`BPAGU_OFS_TPG, 16'h0000);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
